// ===== lsb_pkg.sv
// Purpose: shared constants for the local store block sequencer and its caller
// Assumes: one clock, asynchronous active-high reset
// Notes:   routine pointers are given in hex; octal 001/004/010/020 map to 001/004/008/010
package lsb_pkg;
  localparam int DW      = 16;
  localparam int AW      = 12;
  localparam int PW      = 9;
  localparam int COLS    = 3;
  localparam int ROWS    = 1024;
  localparam int NREGS   = 76;
  localparam int NSETS   = 7;
  // control-ROM bit positions
  localparam int CR_ADDR_LOAD = 0;
  localparam int CR_ADDR_INC  = 1;
  localparam int CR_PTR_COUNT = 2;
  localparam int CR_WRITE     = 3;
  // datapath control word fields
  localparam int CTL_RET      = 15;
  localparam int CTL_SAVE     = 14;
  localparam int CTL_RESTORE  = 13;
  localparam int CTL_IDX_LSB  = 0;
  localparam int CTL_IDX_W    = 5;
  localparam logic [DW-1:0] CTL_IDLE     = 16'h0000;
  localparam logic [DW-1:0] CTL_RET_MASK = 16'h8000;
  // fixed routine entry points
  localparam logic [PW-1:0] RT_STORE_ADDR = 9'h001;
  localparam logic [PW-1:0] RT_WORD_COUNT = 9'h004;
  localparam logic [PW-1:0] RT_WRITE_WORD = 9'h008;
  localparam logic [PW-1:0] RT_READ_WORD  = 9'h010;
  // pointer bits 8:5 pick the routine group, 4:0 the step
  localparam logic [3:0] GRP_MISC       = 4'h0;
  localparam logic [3:0] GRP_SAVE_FIRST = 4'h1;
  localparam logic [3:0] GRP_SAVE_LAST  = 4'h7;
  localparam logic [3:0] GRP_REST_FIRST = 4'h9;
  localparam logic [3:0] GRP_REST_LAST  = 4'hF;
  localparam logic [1:0] COL_NONE       = 2'h3;
  localparam logic [AW-1:0] ADDR_RESET  = 12'h000;
  localparam logic [DW-1:0] DATA_RESET  = 16'h0000;

  // sets: 0 general, 1 working fp, 2 c except constants, 3 user scratch, 4 a, 5 b, 6 c
  function automatic logic [4:0] set_size(input logic [2:0] s);
    case (s)
      3'h0:    set_size = 5'h08;
      3'h1:    set_size = 5'h0C;
      3'h2:    set_size = 5'h0C;
      3'h3:    set_size = 5'h08;
      default: set_size = 5'h10;
    endcase
  endfunction

  // c-except-constants shares the low words of the whole c set
  function automatic logic [6:0] set_base(input logic [2:0] s);
    case (s)
      3'h0:    set_base = 7'h00;
      3'h1:    set_base = 7'h08;
      3'h3:    set_base = 7'h14;
      3'h4:    set_base = 7'h1C;
      3'h5:    set_base = 7'h2C;
      default: set_base = 7'h3C;
    endcase
  endfunction
endpackage

// ===== lsb_link_if.sv
// Purpose: microcontrol transfer port and datapath latch between caller and sequencer
// Assumes: both ends on clk
// Notes:   every signal is driven by a flop at its source end
`timescale 1ns/1ps
interface lsb_link_if (
  input wire logic clk,
  input wire logic rst
);
  import lsb_pkg::*;
  logic          func_strobe;
  logic [PW-1:0] local_store_function_code;
  logic [DW-1:0] datapath_latch;
  logic          store_init;
  logic [DW-1:0] ctl_word;
  logic [DW-1:0] read_data;
  logic          ls_busy;

  modport dev (
    input  clk, rst, func_strobe, local_store_function_code, datapath_latch, store_init,
    output ctl_word, read_data, ls_busy
  );
  modport host (
    input  clk, rst, ctl_word, read_data, ls_busy,
    output func_strobe, local_store_function_code, datapath_latch, store_init
  );
endinterface

// ===== lsb_sequencer.sv
// Purpose: local store sequencer; lets the store array act as a block data store
// Assumes: caller keeps the transfer port conventions; one clk, async rst
// Notes:   routine words come from a constant function, not a memory file
// Overview of operation
// (R1) local_control_rom bit0 loads counter, bit1 increments it
// (R2) bit2 counts pointer, bit3 enables array write
// (R3) routine rom drives datapath control in local store
// (R4) routines save registers to, restore from array
// (R5) caller issues function code, address in latch
// (R6) function code is routine start pointer directly
// (R7) routine 0001: init clears, else loads/writes/increments
// (R8) routine 0004 writes count, then increments
// (R9) routine 0010 loads counter, writes next word
// (R10) routine 0020 loads counter, drives word out
// (R11) whole register sets saved or restored
// (R12) caller latches target address minus one first
// (R13) return only after whole set moved
// (R14) two datapath sections move each microcycle
// (R15) pointer-load cycle runs control bits only
// (R16) partial entry resumes third word after load
// (R17) partial save presets counter to address minus two
// (R18) no port select right after flag clear
// (R19) dedicated microword for transfer port setup
// (R20) pointer loads code, counts on bit2
// (R21) write buffer written only when bit3 set; here buffer_r takes the latch every cycle, bit3 gates the array write
// (R22) counter loads buffer bits 11:0, then counts
// (R23) counter bits 11:10 select output column
`timescale 1ns/1ps
module lsb_sequencer (
  lsb_link_if.dev link
);
  import lsb_pkg::*;

  logic [PW-1:0] ptr_r;
  logic [3:0]    local_control_rom_r;
  logic [DW-1:0] ctl_r;
  logic          busy_r;
  logic [AW-1:0] counter_r;
  logic [DW-1:0] buffer_r;
  logic [DW-1:0] read_r;
  logic [DW-1:0] col_mem [COLS][ROWS];
  logic [PW-1:0] ptr_nxt;
  logic [19:0]   start_word;
  logic [19:0]   next_word;
  logic          clear_word;
  logic [PW-1:0] init_ofs;

  // returns {control-rom bits, datapath control word} for a pointer value
  function automatic logic [19:0] rom_word(input logic [PW-1:0] p);
    logic [3:0]    g;
    logic [4:0]    st;
    logic [4:0]    n;
    logic [3:0]    cr;
    logic [DW-1:0] c;
    g  = p[8:5];
    st = p[4:0];
    n  = 5'h00;
    cr = 4'h0;
    c  = CTL_IDLE;
    if (g == GRP_MISC) begin
      case (p)
        RT_STORE_ADDR: begin
          cr[CR_ADDR_LOAD] = 1'b1;                      // [R7]
          cr[CR_PTR_COUNT] = 1'b1;
        end
        RT_STORE_ADDR + 9'h001: begin
          cr[CR_WRITE]    = 1'b1;                       // [R7]
          cr[CR_ADDR_INC] = 1'b1;
          c[CTL_RET]      = 1'b1;
        end
        RT_WORD_COUNT: begin
          cr[CR_WRITE]    = 1'b1;                       // [R8]
          cr[CR_ADDR_INC] = 1'b1;
          c[CTL_RET]      = 1'b1;
        end
        RT_WRITE_WORD: begin
          cr[CR_ADDR_LOAD] = 1'b1;                      // [R9]
          cr[CR_PTR_COUNT] = 1'b1;
        end
        RT_WRITE_WORD + 9'h001: begin
          cr[CR_WRITE] = 1'b1;                          // [R9]
          c[CTL_RET]   = 1'b1;
        end
        RT_READ_WORD: begin
          cr[CR_ADDR_LOAD] = 1'b1;                      // [R10]
          cr[CR_PTR_COUNT] = 1'b1;
        end
        RT_READ_WORD + 9'h001: begin
          cr[CR_PTR_COUNT] = 1'b1;                      // [R10]
        end
        RT_READ_WORD + 9'h002: begin
          c[CTL_RET]     = 1'b1;                        // [R10]
          c[CTL_RESTORE] = 1'b1;
        end
        default: c[CTL_RET] = 1'b1;
      endcase
    end else if (g >= GRP_SAVE_FIRST && g <= GRP_SAVE_LAST) begin
      // save: buffer holds register st-2 while the caller fetches register st
      n = set_size(3'(g - GRP_SAVE_FIRST));             // [R11]
      if (st == 5'h00) begin
        cr[CR_ADDR_LOAD] = 1'b1;                        // [R12]
        cr[CR_PTR_COUNT] = 1'b1;
      end else if (st == 5'h01) begin
        cr[CR_ADDR_INC]  = 1'b1;                        // [R17]
        cr[CR_PTR_COUNT] = 1'b1;
      end else if (st <= n) begin
        cr = 4'hF & ~(4'h1 << CR_ADDR_LOAD);            // [R14]
      end else begin
        cr[CR_WRITE] = 1'b1;                            // [R13]
        c[CTL_RET]   = 1'b1;
      end
      if (st != 5'h00 && st < n) begin
        c[CTL_SAVE] = 1'b1;                             // [R14]
        c[CTL_IDX_LSB +: CTL_IDX_W] = st;
      end
    end else if (g >= GRP_REST_FIRST && g <= GRP_REST_LAST) begin
      // restore: array read of step k reaches the caller at step k+1
      n = set_size(3'(g - GRP_REST_FIRST));             // [R11]
      if (st == 5'h00) begin
        cr[CR_ADDR_LOAD] = 1'b1;                        // [R12]
        cr[CR_PTR_COUNT] = 1'b1;
      end else if (st <= n) begin
        cr[CR_ADDR_INC]  = 1'b1;
        cr[CR_PTR_COUNT] = 1'b1;
      end else if (st == 5'(n + 5'h01)) begin
        cr[CR_PTR_COUNT] = 1'b1;
      end else begin
        c[CTL_RET] = 1'b1;                              // [R13]
      end
      if (st >= 5'h03 && st <= 5'(n + 5'h02)) begin
        c[CTL_RESTORE] = 1'b1;                          // [R14]
        c[CTL_IDX_LSB +: CTL_IDX_W] = 5'(st - 5'h03);
      end
    end else begin
      c[CTL_RET] = 1'b1;
    end
    rom_word = {cr, c};
  endfunction

  assign ptr_nxt    = ptr_r + {8'h00, local_control_rom_r[CR_PTR_COUNT]};          // [R20]
  assign start_word = rom_word(link.local_store_function_code);        // [R6]
  assign next_word  = rom_word(ptr_nxt);
  assign init_ofs   = ptr_r - RT_STORE_ADDR;
  // only the store-init pass of the first routine writes zero
  assign clear_word = link.store_init && (init_ofs <= 9'h001);        // [R7]

  // routine sequencing; a strobe while busy is ignored
  always_ff @(posedge link.clk or posedge link.rst) begin
    if (link.rst) begin
      ptr_r  <= '0;
      local_control_rom_r <= 4'h0;
      ctl_r  <= CTL_IDLE;
      busy_r <= 1'b0;
    end else if (!busy_r) begin
      if (link.func_strobe) begin
        ptr_r  <= link.local_store_function_code;                      // [R6] [R20]
        local_control_rom_r <= start_word[19:16];                                   // [R15]
        ctl_r  <= start_word[DW-1:0] & CTL_RET_MASK;                   // [R15]
        busy_r <= 1'b1;
      end
    end else if (ctl_r[CTL_RET]) begin
      // caller resumes the cycle after this word; partial entries see the same timing
      ptr_r  <= ptr_r;                                                 // [R16]
      local_control_rom_r <= 4'h0;
      ctl_r  <= CTL_IDLE;
      busy_r <= 1'b0;                                                  // [R13]
    end else begin
      ptr_r  <= ptr_nxt;                                               // [R20]
      local_control_rom_r <= next_word[19:16];
      ctl_r  <= next_word[DW-1:0];                                     // [R3]
    end
  end

  // write buffer takes the datapath latch every cycle
  always_ff @(posedge link.clk or posedge link.rst) begin
    if (link.rst) begin
      buffer_r <= DATA_RESET;
    end else begin
      buffer_r <= link.datapath_latch;                                 // [R21]
    end
  end

  always_ff @(posedge link.clk or posedge link.rst) begin
    if (link.rst) begin
      counter_r <= ADDR_RESET;
    end else if (local_control_rom_r[CR_ADDR_LOAD]) begin
      counter_r <= clear_word ? ADDR_RESET : buffer_r[AW-1:0];         // [R1] [R22]
    end else if (local_control_rom_r[CR_ADDR_INC]) begin
      counter_r <= counter_r + 12'h001;                                // [R1]
    end
  end

  // array has no reset; column 3 is control-store space and is never written here
  always_ff @(posedge link.clk) begin
    if (local_control_rom_r[CR_WRITE] && counter_r[11:10] != COL_NONE) begin        // [R2] [R21]
      col_mem[counter_r[11:10]][counter_r[9:0]] <= clear_word ? DATA_RESET : buffer_r; // [R4]
    end
  end

  always_ff @(posedge link.clk or posedge link.rst) begin
    if (link.rst) begin
      read_r <= DATA_RESET;
    end else if (counter_r[11:10] == COL_NONE) begin
      read_r <= DATA_RESET;
    end else begin
      read_r <= col_mem[counter_r[11:10]][counter_r[9:0]];             // [R23] [R4]
    end
  end

  assign link.ctl_word  = ctl_r;                                       // [R3]
  assign link.read_data = read_r;
  assign link.ls_busy   = busy_r;
endmodule

// ===== lsb_caller.sv
// Purpose: caller end; issues function codes and moves register sets through the latch
// Assumes: sequencer end keeps its routine timing
// Notes:   holds its own register file of all seven sets
`timescale 1ns/1ps
module lsb_caller (
  lsb_link_if.host                 link,
  input  wire logic                start,
  input  wire logic [lsb_pkg::PW-1:0] cmd_code,
  input  wire logic                init,
  input  wire logic [lsb_pkg::AW-1:0] addr,
  input  wire logic [lsb_pkg::DW-1:0] wdata,
  input  wire logic                flag_clear_branch,
  input  wire logic                reg_wr_en,
  input  wire logic [6:0]          reg_wr_idx,
  input  wire logic [lsb_pkg::DW-1:0] reg_wr_data,
  input  wire logic [6:0]          reg_rd_idx,
  output logic      [lsb_pkg::DW-1:0] reg_rd_data,
  output logic      [lsb_pkg::DW-1:0] rdata,
  output logic                     busy,
  output logic                     done
);
  import lsb_pkg::*;

  typedef enum logic [1:0] {HS_IDLE, HS_ISSUE, HS_RUN} lsb_hstate_t;
  lsb_hstate_t   state_r;
  logic          strobe_r;
  logic [PW-1:0] code_r;
  logic [DW-1:0] latch_r;
  logic          init_r;
  logic          first_r;
  logic          flag_r;
  logic          busy_r;
  logic          done_r;
  logic [DW-1:0] rdata_r;
  logic [DW-1:0] rd_r;
  logic [DW-1:0] regs [NREGS];
  logic [3:0]    grp;
  logic [2:0]    set_id;
  logic [6:0]    idx;

  assign grp    = code_r[8:5];
  assign set_id = (grp >= GRP_REST_FIRST) ? 3'(grp - GRP_REST_FIRST) : 3'(grp - GRP_SAVE_FIRST);
  assign idx    = set_base(set_id) + {2'h0, link.ctl_word[CTL_IDX_LSB +: CTL_IDX_W]};

  always_ff @(posedge link.clk or posedge link.rst) begin
    if (link.rst) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_clear_branch;
    end
  end

  always_ff @(posedge link.clk or posedge link.rst) begin
    if (link.rst) begin
      state_r  <= HS_IDLE;
      strobe_r <= 1'b0;
      code_r   <= '0;
      latch_r  <= DATA_RESET;
      init_r   <= 1'b0;
      first_r  <= 1'b0;
      busy_r   <= 1'b0;
      done_r   <= 1'b0;
      rdata_r  <= DATA_RESET;
    end else begin
      done_r <= 1'b0;
      unique case (state_r)
        HS_IDLE: begin
          if (start && !flag_r) begin                                   // [R18]
            // dedicated strobe cycle, nothing else rides on it
            strobe_r <= 1'b1;                                           // [R5] [R19]
            code_r   <= cmd_code;
            init_r   <= init;
            busy_r   <= 1'b1;
            state_r  <= HS_ISSUE;
            if (cmd_code[8:5] != GRP_MISC) begin
              latch_r <= {4'h0, addr - 12'h001};                        // [R12]
            end else if (cmd_code == RT_WORD_COUNT) begin
              latch_r <= wdata;
            end else begin
              latch_r <= {4'h0, addr};                                  // [R5]
            end
          end
        end
        HS_ISSUE: begin
          strobe_r <= 1'b0;
          first_r  <= 1'b1;
          state_r  <= HS_RUN;
          if (code_r == RT_WRITE_WORD) begin
            latch_r <= wdata;
          end
        end
        HS_RUN: begin
          first_r <= 1'b0;
          if (first_r && grp >= GRP_SAVE_FIRST && grp <= GRP_SAVE_LAST) begin
            latch_r <= regs[set_base(set_id)];                          // [R14]
          end else if (link.ctl_word[CTL_SAVE]) begin
            latch_r <= regs[idx];                                       // [R14]
          end
          if (link.ctl_word[CTL_RESTORE] && grp == GRP_MISC) begin
            rdata_r <= link.read_data;
          end
          if (link.ctl_word[CTL_RET]) begin
            busy_r  <= 1'b0;                                            // [R13]
            done_r  <= 1'b1;
            state_r <= HS_IDLE;
          end
        end
      endcase
    end
  end

  // restore captures win over user writes in the same cycle
  always_ff @(posedge link.clk) begin
    if (state_r == HS_RUN && link.ctl_word[CTL_RESTORE] && grp != GRP_MISC) begin
      regs[idx] <= link.read_data;                                      // [R11]
    end else if (reg_wr_en) begin
      regs[reg_wr_idx] <= reg_wr_data;
    end
  end

  always_ff @(posedge link.clk or posedge link.rst) begin
    if (link.rst) begin
      rd_r <= DATA_RESET;
    end else begin
      rd_r <= regs[reg_rd_idx];
    end
  end

  assign link.func_strobe               = strobe_r;
  assign link.local_store_function_code = code_r;
  assign link.datapath_latch            = latch_r;
  assign link.store_init                = init_r;
  assign reg_rd_data                    = rd_r;
  assign rdata                          = rdata_r;
  assign busy                           = busy_r;
  assign done                           = done_r;
endmodule

// ===== lsb_link_asserts.sv
// Purpose: protocol checks on the transfer port between caller and sequencer
// Assumes: one clock domain, rst asynchronous active high
// Notes:   takes the link signals as plain inputs, instantiated beside the link
`timescale 1ns/1ps
module lsb_link_asserts (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic                   func_strobe,
  input wire logic [lsb_pkg::PW-1:0] local_store_function_code,
  input wire logic                   store_init,
  input wire logic [lsb_pkg::DW-1:0] ctl_word,
  input wire logic                   ls_busy
);
  import lsb_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [4:0] cap_cnt_r;
  logic       is_rest;

  // restore groups 9..15 map to sets 0..6
  function automatic logic [4:0] rest_size(input logic [3:0] g);
    case (g)
      4'h9, 4'hC: rest_size = 5'h08;
      4'hA, 4'hB: rest_size = 5'h0C;
      default:    rest_size = 5'h10;
    endcase
  endfunction

  assign is_rest = local_store_function_code[8:5] >= GRP_REST_FIRST;

  // captures counted per routine; cleared by each new strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cap_cnt_r <= 5'h00;
    end else if (func_strobe) begin
      cap_cnt_r <= 5'h00;
    end else if (ls_busy && ctl_word[CTL_RESTORE]) begin
      cap_cnt_r <= cap_cnt_r + 5'h01;
    end
  end

  strobe_when_idle_a: assert property (func_strobe |-> !ls_busy)
    else $error("strobe issued while sequencer busy");
  busy_after_strobe_a: assert property (func_strobe |=> ls_busy)
    else $error("busy did not follow the strobe");
  ptr_load_ctl_a: assert property (func_strobe |=> (ctl_word & ~CTL_RET_MASK) == CTL_IDLE)
    else $error("pointer load cycle drove control bits");
  return_releases_a: assert property (ls_busy && ctl_word[CTL_RET] |=> !ls_busy)
    else $error("busy held after return word");
  busy_bounded_a: assert property ($rose(ls_busy) |-> ##[1:40] !ls_busy)
    else $error("routine ran too long");
  code_held_a: assert property (ls_busy && $past(ls_busy)
      |-> $stable(local_store_function_code) && $stable(store_init))
    else $error("function code changed during routine");
  read_answer_a: assert property (func_strobe && local_store_function_code == RT_READ_WORD
      |-> ##3 ctl_word[CTL_RESTORE])
    else $error("read routine gave no capture at third cycle");
  restore_count_a: assert property (ls_busy && ctl_word[CTL_RET] && is_rest
      |-> cap_cnt_r + 5'(ctl_word[CTL_RESTORE]) == rest_size(local_store_function_code[8:5]))
    else $error("restore moved wrong number of words");
  restore_no_save_a: assert property (ls_busy && is_rest |-> !ctl_word[CTL_SAVE])
    else $error("save bit during restore routine");

  save_seen_c: cover property (ls_busy && ctl_word[CTL_SAVE]);
endmodule

// ===== lsb_sequencer_tb_top.sv
// Purpose: self-checking bench joining caller and sequencer over the link
// Assumes: inputs change on the falling edge; done is a one-cycle pulse
// Notes:   expected words come from the bench's own set tables
`timescale 1ns/1ps
module lsb_sequencer_tb_top;
  import lsb_pkg::*;
`define CHECK(got, exp) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end

  typedef struct packed {
    logic [PW-1:0] code;
    logic          init;
    logic [AW-1:0] addr;
    logic [DW-1:0] val;
  } lsb_row_t;

  logic          clk, rst, start, init, flag_clear_branch, reg_wr_en, busy, done;
  logic [PW-1:0] cmd_code;
  logic [AW-1:0] addr, a0;
  logic [DW-1:0] wdata, reg_wr_data, reg_rd_data, rdata;
  logic [6:0]    reg_wr_idx, reg_rd_idx;
  int            error_cnt, checks, n_cyc, base_cyc;
  lsb_row_t      rows [16];
  int            set_n [7] = '{8, 12, 12, 8, 16, 16, 16};
  int            set_b [7] = '{0, 8, 60, 20, 28, 44, 60};

  lsb_link_if lsb_link_if_i (.clk(clk), .rst(rst));
  lsb_sequencer lsb_sequencer_i (.link(lsb_link_if_i.dev));
  lsb_caller lsb_caller_i (
    .link(lsb_link_if_i.host), .start(start), .cmd_code(cmd_code), .init(init),
    .addr(addr), .wdata(wdata), .flag_clear_branch(flag_clear_branch),
    .reg_wr_en(reg_wr_en), .reg_wr_idx(reg_wr_idx), .reg_wr_data(reg_wr_data),
    .reg_rd_idx(reg_rd_idx), .reg_rd_data(reg_rd_data), .rdata(rdata),
    .busy(busy), .done(done)
  );
  lsb_link_asserts lsb_link_asserts_i (
    .clk(clk), .rst(rst), .func_strobe(lsb_link_if_i.func_strobe),
    .local_store_function_code(lsb_link_if_i.local_store_function_code),
    .store_init(lsb_link_if_i.store_init), .ctl_word(lsb_link_if_i.ctl_word),
    .ls_busy(lsb_link_if_i.ls_busy)
  );

  task automatic print_verdict();
    if (error_cnt == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // mode[0]: flag-clear branch first, start held two cycles; mode[1]: stray start while busy
  task automatic run_op(input logic [PW-1:0] c, input logic i, input logic [AW-1:0] a,
                        input logic [DW-1:0] d, input logic [1:0] mode, output int cyc);
    int k;
    @(negedge clk);
    if (mode[0]) begin
      flag_clear_branch = 1'b1;
      @(negedge clk);
      flag_clear_branch = 1'b0;
    end
    cmd_code = c;
    init = i;
    addr = a;
    wdata = d;
    start = 1'b1;
    @(negedge clk);
    if (mode[0]) @(negedge clk);
    start = 1'b0;
    `CHECK(busy, 1'b1)
    for (k = 0; k < 100 && done !== 1'b1; k++) begin
      @(negedge clk);
      start = mode[1] && k == 1;
      if (start) begin
        addr = 12'h0FE;
        wdata = 16'hDEAD;
      end
    end
    cyc = k;
    if (k == 100) begin
      error_cnt++;
      print_verdict();
    end
  endtask

  task automatic wr_reg(input int idx, input logic [DW-1:0] d);
    @(negedge clk);
    reg_wr_en = 1'b1;
    reg_wr_idx = idx[6:0];
    reg_wr_data = d;
    @(negedge clk);
    reg_wr_en = 1'b0;
  endtask

  task automatic chk_reg(input int idx, input logic [DW-1:0] exp);
    @(negedge clk);
    reg_rd_idx = idx[6:0];
    @(negedge clk);
    `CHECK(reg_rd_data, exp)
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    {start, init, flag_clear_branch, reg_wr_en} = 4'h0;
    {cmd_code, addr, wdata, reg_wr_data, reg_wr_idx, reg_rd_idx} = '0;
    error_cnt = 0;
    checks = 0;
    rst = 1'b1;
    rows = '{'{RT_WRITE_WORD, 1'b0, 12'h0FE, 16'h1111}, '{RT_WRITE_WORD, 1'b0, 12'h0FF, 16'h1234},
             '{RT_READ_WORD,  1'b0, 12'h0FF, 16'h1234}, '{RT_WRITE_WORD, 1'b0, 12'h3FF, 16'hFFFF},
             '{RT_WRITE_WORD, 1'b0, 12'h400, 16'h5A5A}, '{RT_READ_WORD,  1'b0, 12'h3FF, 16'hFFFF},
             '{RT_READ_WORD,  1'b0, 12'h400, 16'h5A5A}, '{RT_WRITE_WORD, 1'b0, 12'h000, 16'hBEEF},
             '{RT_STORE_ADDR, 1'b1, 12'h000, 16'h0000}, '{RT_READ_WORD,  1'b0, 12'h000, 16'h0000},
             '{RT_WRITE_WORD, 1'b0, 12'hC00, 16'h7777}, '{RT_READ_WORD,  1'b0, 12'hC00, 16'h0000},
             '{RT_STORE_ADDR, 1'b0, 12'h020, 16'h0000}, '{RT_WORD_COUNT, 1'b0, 12'h000, 16'h0ABC},
             '{RT_READ_WORD,  1'b0, 12'h020, 16'h0020}, '{RT_READ_WORD,  1'b0, 12'h021, 16'h0ABC}};
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    foreach (rows[r]) begin
      run_op(rows[r].code, rows[r].init, rows[r].addr, rows[r].val, 2'b00, n_cyc);
      if (rows[r].code == RT_READ_WORD) `CHECK(rdata, rows[r].val)
    end
    // a start right after a flag-clear branch must lose exactly one cycle
    run_op(RT_WRITE_WORD, 1'b0, 12'h0FF, 16'h4321, 2'b00, base_cyc);
    run_op(RT_WRITE_WORD, 1'b0, 12'h0FF, 16'h4321, 2'b01, n_cyc);
    `CHECK(n_cyc, base_cyc)
    run_op(RT_WRITE_WORD, 1'b0, 12'h0FF, 16'h2222, 2'b10, n_cyc);
    run_op(RT_READ_WORD, 1'b0, 12'h0FE, 16'h0000, 2'b00, n_cyc);
    `CHECK(rdata, 16'h1111)
    for (int s = 0; s < 7; s++) begin
      a0 = 12'h200 + 12'(s * 32);
      for (int k = 0; k < set_n[s]; k++) wr_reg(set_b[s] + k, {4'hA, s[3:0], k[7:0]});
      run_op({s[3:0] + 4'h1, 5'h00}, 1'b0, a0, 16'h0000, 2'b00, n_cyc);
      run_op(RT_READ_WORD, 1'b0, a0 + 12'(set_n[s] - 1), 16'h0000, 2'b00, n_cyc);
      `CHECK(rdata, {4'hA, s[3:0], 8'(set_n[s] - 1)})
      for (int k = 0; k < set_n[s]; k++) wr_reg(set_b[s] + k, 16'h0000);
      run_op({s[3:0] + 4'h9, 5'h00}, 1'b0, a0, 16'h0000, 2'b00, n_cyc);
      for (int k = 0; k < set_n[s]; k++) chk_reg(set_b[s] + k, {4'hA, s[3:0], k[7:0]});
    end
    // reset in mid-routine clears the handshake outputs
    cmd_code = {GRP_SAVE_LAST, 5'h00};
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (3) @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    `CHECK(busy, 1'b0)
    `CHECK(done, 1'b0)
    `CHECK(lsb_link_if_i.ls_busy, 1'b0)
    `CHECK(lsb_link_if_i.ctl_word, CTL_IDLE)
    rst = 1'b0;
    run_op(RT_READ_WORD, 1'b0, 12'h0FE, 16'h0000, 2'b00, n_cyc);
    `CHECK(rdata, 16'h1111)
    print_verdict();
  end
endmodule
